// ### cpm_defs.svh
// constants for the control port mode entry block and its host
// Contract
// - strapped mode configures from pins, feature subset
// - host keeps straps stable, reset held
// - host mode turns four pins into port
// - host writes enable flag bit 7
// - enable set: pins ignored, registers rule
// - crystal driver: buffered crystal copy on clock pin
// - i2c start waits 600 ns after reset
// - i2c bus idle 4.7 us between transfers
// - spi select waits 20 ns after reset
// - spi select high 1.0 us between transfers
`ifndef CPM_DEFS_SVH
`define CPM_DEFS_SVH

`define CLK_MHZ                 125
// least time in ns to whole clock cycles, rounded up
`define CYC_MIN(ns)             ((((ns) * `CLK_MHZ) + 999) / 1000)

`define T_RST_TO_I2C_START_NS   600
`define T_I2C_BUS_FREE_NS       4700
`define T_RST_TO_SPI_CS_NS      20
`define T_SPI_CS_HIGH_NS        1000
`define T_SCLK_HALF_NS          66
`define T_RESET_HOLD_NS         1000

`define GLOBAL_CONTROL_ADDR     7'h00
`define GLOBAL_CONTROL_RESET    8'h00
`define GC_ENABLE_BIT           7
`define GC_MODE_LSB             0
`define GC_FORMAT_LSB           2
`define STRAP_MODE_LSB          0
`define STRAP_FORMAT_LSB        2

`define FRAME_BITS              5'h10
`define HEADER_BITS             5'h08

`define PIN_CS_N                0
`define PIN_SCLK                1
`define PIN_MOSI                2
`define PIN_MISO                3

`endif

// ### cpm_pkg.sv
// types for the control port mode entry block and its host
package cpm_pkg;

    typedef enum logic [4:0] {
        HOST_RESET = 5'h01,
        HOST_GUARD = 5'h02,
        HOST_IDLE  = 5'h04,
        HOST_SHIFT = 5'h08,
        HOST_GAP   = 5'h10
    } host_state_t;

    typedef struct packed {
        logic        host_mode;
        logic [3:0]  strap_latch;
        logic [7:0]  global_control;
        logic [4:0]  bit_cnt;
        logic [15:0] shift_in;
        logic [7:0]  shift_out;
        logic        sclk_prev;
        logic        miso;
        logic        miso_oe_n;
        logic [1:0]  mode_sel;
        logic [1:0]  format_sel;
        logic        port_active;
        logic        mclk;
    } device_regs_t;

    typedef struct packed {
        host_state_t state;
        logic [15:0] cnt;
        logic [4:0]  bit_cnt;
        logic [15:0] shift;
        logic [7:0]  rdata;
        logic        done;
        logic        ready;
        logic        reset_pin_n;
        logic        ctl_mode;
        logic [3:0]  pin_o;
        logic [3:0]  pin_oe_n;
    } host_regs_t;

endpackage

// ### cpm_link_if.sv
// four multi-use pins, reset pin and mode pin between host and device
interface cpm_link_if;
    logic       reset_pin_n;
    logic       ctl_mode;
    logic [3:0] host_pin_o;
    logic [3:0] host_pin_oe_n;
    logic       dev_miso_o;
    logic       dev_miso_oe_n;
    wire  [3:0] pin;

    // pins are pulled high when nobody drives them
    assign pin[0] = !host_pin_oe_n[0] ? host_pin_o[0] : 1'b1;
    assign pin[1] = !host_pin_oe_n[1] ? host_pin_o[1] : 1'b1;
    assign pin[2] = !host_pin_oe_n[2] ? host_pin_o[2] : 1'b1;
    assign pin[3] = !host_pin_oe_n[3] ? host_pin_o[3] :
                    (!dev_miso_oe_n ? dev_miso_o : 1'b1);

    modport device (
        input  reset_pin_n,
        input  ctl_mode,
        input  pin,
        output dev_miso_o,
        output dev_miso_oe_n
    );

    modport host (
        output reset_pin_n,
        output ctl_mode,
        output host_pin_o,
        output host_pin_oe_n,
        input  pin
    );
endinterface

// ### cpm_sync2.sv
// two flip-flop synchroniser for pin inputs
module cpm_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // pins in, synchronised levels out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ### cpm_device.sv
// device end: strap or control port configuration and master clock buffer
`include "cpm_defs.svh"
module cpm_device (
    // clock and reset
    input  wire logic  clk,
    input  wire logic  rstn,
    // link
    cpm_link_if.device link,
    // crystal clock source
    input  wire logic  crystal_input,
    input  wire logic  crystal_used,
    output logic       mclk_out,
    // effective configuration
    output logic [1:0] mode_sel,
    output logic [1:0] format_sel,
    output logic       port_active,
    output logic       host_mode
);
    cpm_pkg::device_regs_t s;
    cpm_pkg::device_regs_t n;
    logic [7:0]            sync_q;
    logic [3:0]            pins_s;
    logic                  rst_pin_n_s;
    logic                  ctl_mode_s;
    logic                  xtal_s;
    logic                  xtal_used_s;
    logic                  rise;
    logic                  fall;
    logic [7:0]            gc_byte;

    ////////////////////////////////////////////////////////////////////////////
    cpm_sync2 #(.WIDTH(8)) pin_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({crystal_used, crystal_input, link.ctl_mode, link.reset_pin_n, link.pin}),
        .q    (sync_q)
    );

    assign pins_s      = sync_q[3:0];
    assign rst_pin_n_s = sync_q[4];
    assign ctl_mode_s  = sync_q[5];
    assign xtal_s      = sync_q[6];
    assign xtal_used_s = sync_q[7];
    assign rise        = pins_s[`PIN_SCLK] & ~s.sclk_prev;
    assign fall        = ~pins_s[`PIN_SCLK] & s.sclk_prev;
    assign gc_byte     = {s.shift_in[6:0], pins_s[`PIN_MOSI]};

    function automatic logic [7:0] read_reg(input logic [6:0] addr, input logic [7:0] gc);
        read_reg = (addr == `GLOBAL_CONTROL_ADDR) ? gc : 8'h00;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        n           = s;
        n.sclk_prev = pins_s[`PIN_SCLK];
        n.mclk      = xtal_used_s & xtal_s;
        if (!rst_pin_n_s) begin
            n.host_mode      = ctl_mode_s;
            n.strap_latch    = pins_s;
            n.global_control = `GLOBAL_CONTROL_RESET;
            n.bit_cnt        = 5'h00;
            n.shift_in       = 16'h0000;
            n.shift_out      = 8'h00;
            n.miso           = 1'b0;
            n.miso_oe_n      = 1'b1;
        end else if (s.host_mode) begin
            if (pins_s[`PIN_CS_N]) begin
                n.bit_cnt   = 5'h00;
                n.miso_oe_n = 1'b1;
            end else begin
                n.miso_oe_n = 1'b0;
                if (rise && s.bit_cnt < `FRAME_BITS) begin
                    n.shift_in = {s.shift_in[14:0], pins_s[`PIN_MOSI]};
                    n.bit_cnt  = s.bit_cnt + 5'h01;
                    if (s.bit_cnt == `HEADER_BITS - 5'h01) begin
                        n.shift_out = read_reg(gc_byte[6:0], s.global_control);
                    end
                    if (s.bit_cnt == `FRAME_BITS - 5'h01 && !s.shift_in[14] &&
                        s.shift_in[13:7] == `GLOBAL_CONTROL_ADDR) begin
                        n.global_control = gc_byte;
                    end
                end
                if (fall && s.bit_cnt >= `HEADER_BITS && s.bit_cnt < `FRAME_BITS) begin
                    n.miso      = s.shift_out[7];
                    n.shift_out = {s.shift_out[6:0], 1'b0};
                end
            end
        end
        // configuration source
        n.port_active = s.host_mode & s.global_control[`GC_ENABLE_BIT];
        if (n.port_active) begin
            n.mode_sel   = s.global_control[`GC_MODE_LSB +: 2];
            n.format_sel = s.global_control[`GC_FORMAT_LSB +: 2];
        end else if (s.host_mode) begin
            n.mode_sel   = s.strap_latch[`STRAP_MODE_LSB +: 2];
            n.format_sel = s.strap_latch[`STRAP_FORMAT_LSB +: 2];
        end else begin
            n.mode_sel   = pins_s[`STRAP_MODE_LSB +: 2];
            n.format_sel = pins_s[`STRAP_FORMAT_LSB +: 2];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '{host_mode: 1'b0, strap_latch: 4'h0,
                   global_control: `GLOBAL_CONTROL_RESET, bit_cnt: 5'h00,
                   shift_in: 16'h0000, shift_out: 8'h00, sclk_prev: 1'b0,
                   miso: 1'b0, miso_oe_n: 1'b1, mode_sel: 2'h0,
                   format_sel: 2'h0, port_active: 1'b0, mclk: 1'b0};
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign link.dev_miso_o    = s.miso;
    assign link.dev_miso_oe_n = s.miso_oe_n;
    assign mclk_out           = s.mclk;
    assign mode_sel           = s.mode_sel;
    assign format_sel         = s.format_sel;
    assign port_active        = s.port_active;
    assign host_mode          = s.host_mode;
endmodule

// ### cpm_host.sv
// host end: reset sequencing, strap driving and control port transfers
`include "cpm_defs.svh"
module cpm_host (
    // clock and reset
    input  wire logic  clk,
    input  wire logic  rstn,
    // link
    cpm_link_if.host   link,
    // setup
    input  wire logic  proto_i2c,
    input  wire logic  host_mode_req,
    input  wire logic [3:0] strap_cfg,
    // request
    input  wire logic  start,
    input  wire logic  rw,
    input  wire logic [6:0] addr,
    input  wire logic [7:0] wdata,
    // answer
    output logic       ready,
    output logic       done,
    output logic [7:0] rdata
);
    localparam logic [15:0] RESET_CYC = 16'(`CYC_MIN(`T_RESET_HOLD_NS));
    localparam logic [15:0] HALF_CYC  = 16'(`CYC_MIN(`T_SCLK_HALF_NS));
    localparam logic [15:0] I2C_RST   = 16'(`CYC_MIN(`T_RST_TO_I2C_START_NS));
    localparam logic [15:0] I2C_FREE  = 16'(`CYC_MIN(`T_I2C_BUS_FREE_NS));
    localparam logic [15:0] SPI_RST   = 16'(`CYC_MIN(`T_RST_TO_SPI_CS_NS));
    localparam logic [15:0] SPI_HIGH  = 16'(`CYC_MIN(`T_SPI_CS_HIGH_NS));

    cpm_pkg::host_regs_t s;
    cpm_pkg::host_regs_t n;
    logic                miso_s;

    cpm_sync2 #(.WIDTH(1)) miso_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    (link.pin[`PIN_MISO]),
        .q    (miso_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        n      = s;
        n.done = 1'b0;
        unique case (s.state)
            cpm_pkg::HOST_RESET: begin
                n.ctl_mode = host_mode_req;
                n.pin_o    = strap_cfg;
                n.pin_oe_n = 4'h0;
                if (s.cnt > 16'h0001) begin
                    n.cnt = s.cnt - 16'h0001;
                end else begin
                    n.reset_pin_n = 1'b1;
                    n.cnt         = proto_i2c ? I2C_RST : SPI_RST;
                    n.state       = cpm_pkg::HOST_GUARD;
                end
            end
            cpm_pkg::HOST_GUARD: begin
                if (s.cnt > 16'h0001) begin
                    n.cnt = s.cnt - 16'h0001;
                end else begin
                    n.state = cpm_pkg::HOST_IDLE;
                    n.ready = s.ctl_mode;
                    if (s.ctl_mode) begin
                        n.pin_o    = 4'h3;
                        n.pin_oe_n = 4'h8;
                    end
                end
            end
            cpm_pkg::HOST_IDLE: begin
                if (start && s.ready) begin
                    n.shift                = {rw, addr, wdata};
                    n.pin_o[`PIN_CS_N]     = 1'b0;
                    n.pin_o[`PIN_SCLK]     = 1'b0;
                    n.pin_o[`PIN_MOSI]     = rw;
                    n.cnt                  = HALF_CYC;
                    n.bit_cnt              = 5'h00;
                    n.ready                = 1'b0;
                    n.state                = cpm_pkg::HOST_SHIFT;
                end
            end
            cpm_pkg::HOST_SHIFT: begin
                if (s.cnt > 16'h0001) begin
                    n.cnt = s.cnt - 16'h0001;
                end else begin
                    n.cnt = HALF_CYC;
                    if (!s.pin_o[`PIN_SCLK]) begin
                        if (s.bit_cnt == `FRAME_BITS) begin
                            n.pin_o[`PIN_CS_N] = 1'b1;
                            n.done             = 1'b1;
                            n.cnt = proto_i2c ? I2C_FREE : SPI_HIGH;
                            n.state            = cpm_pkg::HOST_GAP;
                        end else begin
                            n.pin_o[`PIN_SCLK] = 1'b1;
                            n.rdata            = {s.rdata[6:0], miso_s};
                            n.bit_cnt          = s.bit_cnt + 5'h01;
                        end
                    end else begin
                        n.pin_o[`PIN_SCLK] = 1'b0;
                        n.shift            = {s.shift[14:0], 1'b0};
                        n.pin_o[`PIN_MOSI] = s.shift[14];
                    end
                end
            end
            cpm_pkg::HOST_GAP: begin
                if (s.cnt > 16'h0001) begin
                    n.cnt = s.cnt - 16'h0001;
                end else begin
                    n.ready = 1'b1;
                    n.state = cpm_pkg::HOST_IDLE;
                end
            end
            default: begin
                n.state = cpm_pkg::HOST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '{state: cpm_pkg::HOST_RESET, cnt: RESET_CYC, bit_cnt: 5'h00,
                   shift: 16'h0000, rdata: 8'h00, done: 1'b0, ready: 1'b0,
                   reset_pin_n: 1'b0, ctl_mode: 1'b0, pin_o: 4'h0,
                   pin_oe_n: 4'h0};
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign link.reset_pin_n   = s.reset_pin_n;
    assign link.ctl_mode      = s.ctl_mode;
    assign link.host_pin_o    = s.pin_o;
    assign link.host_pin_oe_n = s.pin_oe_n;
    assign ready              = s.ready;
    assign done               = s.done;
    assign rdata              = s.rdata;
endmodule

// ### cpm_link_checker.sv
// assertions on the link between the host end and the device end
`include "cpm_defs.svh"
module cpm_link_checker (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // link
    input  wire logic       reset_pin_n,
    input  wire logic       ctl_mode,
    input  wire logic [3:0] host_pin_o,
    input  wire logic [3:0] host_pin_oe_n,
    input  wire logic       dev_miso_o,
    input  wire logic       dev_miso_oe_n,
    input  wire logic [3:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [9:0] lo_cnt;
    logic [9:0] up_cnt;
    logic [9:0] hi_cnt;
    logic [4:0] rises;
    logic       seen;
    logic       sclk_q;
    logic       hm;

    assign hm = ctl_mode && reset_pin_n;

    ////////////////////////////////////////////////////////////////////////////
    // saturating counters of reset low, reset high, select high; wrapping count of clock rises
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lo_cnt <= 10'h000;
            up_cnt <= 10'h000;
            hi_cnt <= 10'h000;
            rises  <= 5'h00;
            seen   <= 1'b0;
            sclk_q <= 1'b1;
        end else begin
            lo_cnt <= reset_pin_n ? 10'h000 : lo_cnt + {9'h000, ~&lo_cnt};
            up_cnt <= !reset_pin_n ? 10'h000 : up_cnt + {9'h000, ~&up_cnt};
            hi_cnt <= !pin[0] ? 10'h000 : hi_cnt + {9'h000, ~&hi_cnt};
            rises  <= pin[0] ? 5'h00 : rises + {4'h0, pin[1] && !sclk_q};
            seen   <= reset_pin_n && (seen || (hm && !pin[0]));
            sclk_q <= pin[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_reset_hold_low: assert property ($rose(reset_pin_n)
        |-> lo_cnt >= 10'(`CYC_MIN(`T_RESET_HOLD_NS)))
        else $error("reset pin released too early");
    a_strap_pins_stable: assert property (!ctl_mode && reset_pin_n && $past(reset_pin_n)
        |-> $stable(pin))
        else $error("strap pins moved in strapped mode");
    a_select_after_reset: assert property ($fell(pin[0]) && hm
        |-> up_cnt >= 10'(`CYC_MIN(`T_RST_TO_SPI_CS_NS)))
        else $error("select fell too soon after reset");
    a_select_gap_time: assert property ($fell(pin[0]) && hm && seen
        |-> hi_cnt >= 10'(`CYC_MIN(`T_SPI_CS_HIGH_NS)))
        else $error("select high gap too short");
    a_mosi_steady_rise: assert property ($rose(pin[1]) && hm && !pin[0]
        |-> $stable(host_pin_o[`PIN_MOSI]))
        else $error("data in pin changed at serial clock rise");
    a_miso_steady_rise: assert property ($rose(pin[1]) && hm && !dev_miso_oe_n
        |-> $stable(dev_miso_o))
        else $error("data out pin changed at serial clock rise");
    a_frame_length: assert property ($rose(pin[0]) && hm && seen |-> rises == 5'h10)
        else $error("frame without sixteen clock rises");
    a_sclk_high_time: assert property ($rose(pin[1]) && hm && !pin[0] |-> pin[1] [*8])
        else $error("serial clock high phase too short");
    a_miso_host_only: assert property (!dev_miso_oe_n |-> hm)
        else $error("device drove data pin outside host mode");
    a_miso_release: assert property ($rose(pin[0]) |-> ##5 dev_miso_oe_n)
        else $error("device kept data pin after frame");
    a_single_driver: assert property (!dev_miso_oe_n |-> host_pin_oe_n[3])
        else $error("host and device both drive data pin");

    c_frame_done: cover property ($rose(pin[0]) && hm && seen);
    c_strapped_run: cover property ($rose(reset_pin_n) && !ctl_mode);
    c_device_reply: cover property (!dev_miso_oe_n);
endmodule

// ### control_port_mode_entry_bench.sv
// self-checking bench: host end and device end joined over the link
`include "cpm_defs.svh"
module control_port_mode_entry_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk           = 1'b0;
    logic       rstn          = 1'b0;
    logic       crystal_input = 1'b0;
    logic       crystal_used  = 1'b0;
    logic       proto_i2c     = 1'b0;
    logic       host_mode_req = 1'b0;
    logic [3:0] strap_cfg     = 4'hb;
    logic       start         = 1'b0;
    logic       rw            = 1'b0;
    logic [6:0] addr          = 7'h00;
    logic [7:0] wdata         = 8'h00;
    logic       mclk_out;
    logic [1:0] mode_sel;
    logic [1:0] format_sel;
    logic       port_active;
    logic       host_mode;
    logic       ready;
    logic       done;
    logic [7:0] rdata;
    int         err_total     = 0;
    int         compares      = 0;

    always #4 clk = ~clk;

    cpm_link_if link ();
    cpm_device cpm_device_i (.clk(clk), .rstn(rstn), .link(link),
        .crystal_input(crystal_input), .crystal_used(crystal_used), .mclk_out(mclk_out),
        .mode_sel(mode_sel), .format_sel(format_sel), .port_active(port_active),
        .host_mode(host_mode));
    cpm_host cpm_host_i (.clk(clk), .rstn(rstn), .link(link), .proto_i2c(proto_i2c),
        .host_mode_req(host_mode_req), .strap_cfg(strap_cfg), .start(start), .rw(rw),
        .addr(addr), .wdata(wdata), .ready(ready), .done(done), .rdata(rdata));
    cpm_link_checker cpm_link_checker_i (.clk(clk), .rstn(rstn),
        .reset_pin_n(link.reset_pin_n), .ctl_mode(link.ctl_mode),
        .host_pin_o(link.host_pin_o), .host_pin_oe_n(link.host_pin_oe_n),
        .dev_miso_o(link.dev_miso_o), .dev_miso_oe_n(link.dev_miso_oe_n), .pin(link.pin));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // reset both ends, then time the guard from reset pin rise to ready
    task automatic do_reset(input logic i2c, input logic hm, input logic [3:0] straps);
        int n;
        int guard;
        guard = i2c ? `CYC_MIN(`T_RST_TO_I2C_START_NS) : `CYC_MIN(`T_RST_TO_SPI_CS_NS);
        @(negedge clk);
        rstn = 1'b0;
        proto_i2c = i2c;
        host_mode_req = hm;
        strap_cfg = straps;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        n = 0;
        while (link.reset_pin_n !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk("reset pin", link.reset_pin_n, 8'h01);
        n = 0;
        while (hm && ready !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk("ready", ready, {7'h00, hm});
        chk("guard", !hm || n >= guard, 8'h01);
    endtask

    // one frame; ready must already be high; gap is the least select high time
    task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] d,
                        input logic [7:0] exp, input int gap);
        int n;
        @(negedge clk);
        start = 1'b1;
        rw = r;
        addr = a;
        wdata = d;
        @(negedge clk);
        start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk("done", done, 8'h01);
        if (r)
            chk("rdata", rdata, exp);
        n = 0;
        while (ready !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        chk("ready again", ready, 8'h01);
        chk("gap", n + 2 >= gap, 8'h01);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic hit;
        // strapped mode: mode 11, format 10, select strap high
        do_reset(1'b0, 1'b0, 4'b1011);
        repeat (10) @(negedge clk);
        chk("strap mode", mode_sel, 8'h03);
        chk("strap format", format_sel, 8'h02);
        chk("host mode", host_mode, 8'h00);
        hit = 1'b0;
        start = 1'b1;
        repeat (400) begin
            @(negedge clk);
            hit = hit | (done === 1'b1) | (ready === 1'b1);
        end
        start = 1'b0;
        chk("refused", hit, 8'h00);
        for (int i = 0; i < 4; i++) begin
            crystal_used = i[1];
            crystal_input = i[0];
            repeat (5) @(negedge clk);
            chk("mclk", mclk_out, {7'h00, i[1] & i[0]});
        end
        // spi host mode, straps latched during reset until enable is set
        do_reset(1'b0, 1'b1, 4'b0111);
        chk("host mode", host_mode, 8'h01);
        chk("port off", port_active, 8'h00);
        chk("latched mode", mode_sel, 8'h03);
        chk("latched format", format_sel, 8'h01);
        xfer(1'b1, 7'h00, 8'h00, 8'h00, 125);
        xfer(1'b0, 7'h00, 8'h89, 8'h00, 125);
        chk("port on", port_active, 8'h01);
        chk("reg mode", mode_sel, 8'h01);
        chk("reg format", format_sel, 8'h02);
        xfer(1'b0, 7'h05, 8'hff, 8'h00, 125);
        xfer(1'b1, 7'h05, 8'h00, 8'h00, 125);
        xfer(1'b1, 7'h00, 8'h00, 8'h89, 125);
        // i2c timing guards
        do_reset(1'b1, 1'b1, 4'b0011);
        xfer(1'b0, 7'h00, 8'h82, 8'h00, 588);
        xfer(1'b1, 7'h00, 8'h00, 8'h82, 588);
        chk("i2c mode", mode_sel, 8'h02);
        chk("i2c format", format_sel, 8'h00);
        end_sim();
    end

    initial begin
        #200000;
        err_total++;
        end_sim();
    end
endmodule
